// ==== verilog/ext_bus_pins.sv ====
// Notes on behaviour
// (R1) Fetch strobe low during external code reads.
// (R2) Fetch strobe high except external code fetches.
// (R3) Latch code source pin at reset release.
// (R4) Latched zero: all code fetched externally.
// (R5) Latched one: internal below limit, external above.
// (R6) After reset the pin acts as wait.
// (R7) Wait high stretches the bus cycle.
// (R8) Bus clock output copies the CPU clock; the code toggles it on every clock, at half the CPU clock rate.
// (R9) Software setting disables bus clock output.
// (R10) Reset: port latches ones, quasi-bidirectional mode.
// (R11) Each port pin follows its own mode.
// (R12) Bus use: port carries address 11:4, data.
// (R13) Address latch pulses only for bus cycles.
// (R14) Wait synchronised, checked every access cycle.
`timescale 1ns/100ps
`default_nettype none
`include "ext_bus_cfg.svh"

module ext_bus_pins
   import ext_bus_pkg::*;
#(
   parameter int unsigned INT_CODE_BYTES = `INT_CODE_BYTES,
   parameter logic [3:0]  STROBE_MIN     = `STROBE_MIN_CYCLES
)(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        link_clk,
   input  wire logic        code_source_select_n,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic        req_code,
   input  wire logic        req_write,
   input  wire logic [23:0] req_addr,
   input  wire logic [7:0]  req_wdata,
   output logic             resp_valid,
   output logic             resp_internal,
   output logic [7:0]       resp_rdata,
   output logic             code_ext_only,
   input  wire logic        clk_out_en,
   input  wire logic        cfg_wr,
   input  wire logic [15:0] cfg_mode,
   input  wire logic        latch_wr,
   input  wire logic [7:0]  latch_data,
   output logic [7:0]       port_read,
   output logic             program_fetch_strobe_n,
   output logic             read_strobe_n,
   output logic             write_strobe_n,
   output logic             address_latch_enable,
   output logic             bus_clock_output,
   output logic [23:0]      bus_addr,
   input  wire logic [7:0]  low_byte_port_in,
   output logic [7:0]       low_byte_port_out,
   output logic [7:0]       low_byte_port_oe
);

   generate
      if (INT_CODE_BYTES > 32'h0100_0000 || STROBE_MIN == 4'h0 ||
          STROBE_MIN == 4'hf) begin : g_bad_param
         $error("ext_bus_pins: parameter out of range");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////

   localparam core_state_t CORE_RESET = '{
      state:   ST_IDLE,
      latch:    `PORT_LATCH_RESET,
      port_out: `PORT_LATCH_RESET,
      mode:     `PORT_MODE_RESET,
      fetch_n: 1'b1,
      rd_n:    1'b1,
      wr_n:    1'b1,
      default: '0
   };

   core_state_t s;
   core_state_t n;

   pin_link_if lk ();

   link_capture i_link_capture (
      .link_clk (link_clk),
      .wait_pin (code_source_select_n),
      .lk       (lk.link)
   );

   // Internal code is only used for fetches below the limit, and only
   // when the strap allowed it; data always goes off chip.
   function automatic logic is_external(input logic        code,
                                        input logic [23:0] a,
                                        input logic        ext_only);
      return !code || ext_only || ({1'b0, a} >= 25'(INT_CODE_BYTES));
   endfunction

   // Returns {out, oe} for a general purpose pin.
   function automatic logic [1:0] pin_drive(input port_mode_t m,
                                            input logic       latch,
                                            input logic       boost);
      logic [1:0] r;
      r = 2'h0;
      unique case (m)
         MODE_PUSH_PULL:  r = {latch, 1'b1};
         MODE_OPEN_DRAIN: r = {1'b0, !latch};
         MODE_QUASI:      r = {latch, !latch || boost};
         MODE_INPUT_ONLY: r = 2'h0;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////

   always_comb begin
      n               = s;
      n.resp_valid    = 1'b0;
      n.resp_internal = 1'b0;
      // The first stages feed only the second stages.
      n.wsync1        = lk.wait_level; // R14
      n.wsync2        = s.wsync1; // R14
      n.pin_s1        = low_byte_port_in;
      n.pin_s2        = s.pin_s1;
      n.port_read     = s.pin_s2;

      // The synchronisers restart at reset, so the strap is taken only
      // once they carry the pin again.
      if (!s.strap_done) begin
         if (s.settle == `STRAP_SETTLE_CYCLES) begin
            n.strap_done = 1'b1; // R3
            n.ext_only   = !s.wsync2; // R3
         end else begin
            n.settle = s.settle + 3'h1;
         end
      end

      if (cfg_wr) begin
         n.mode = cfg_mode; // R11
      end
      if (latch_wr) begin
         n.latch = latch_data;
      end
      // A quasi pin released from low gets one clock of strong drive
      // to speed the rising edge past the weak pull-up.
      for (int i = 0; i < 8; i++) begin
         n.boost[i] = latch_wr && !s.latch[i] && latch_data[i] &&
                      port_mode_t'(n.mode[2*i +: 2]) == MODE_QUASI;
      end

      n.clk_out = clk_out_en ? !s.clk_out : 1'b0; // R8 R9

      unique case (s.state)
         ST_IDLE: begin
            if (req_valid && s.req_ready) begin
               n.code  = req_code;
               n.write = req_write && !req_code;
               n.addr  = req_addr;
               n.wdata = req_wdata;
               n.ext   = is_external(req_code, req_addr, s.ext_only); // R4 R5
               if (n.ext) begin
                  n.state = ST_ADDR;
               end else begin
                  n.resp_valid    = 1'b1; // R5
                  n.resp_internal = 1'b1; // R5
               end
            end
         end
         ST_ADDR: begin
            n.state = ST_HOLD;
         end
         ST_HOLD: begin
            n.state = ST_STROBE;
            n.cnt   = 4'h1;
         end
         ST_STROBE: begin
            if (s.cnt != 4'hf) begin
               n.cnt = s.cnt + 4'h1;
            end
            if (s.cnt >= STROBE_MIN && !s.wsync2) begin // R7 R14
               n.state = ST_DONE;
            end
         end
         ST_DONE: begin
            n.state      = ST_IDLE;
            n.resp_valid = 1'b1;
            // The pins need two clocks through the synchroniser, so the
            // byte is taken here, from the clock before the last clock of the strobe.
            if (!s.write) begin
               n.rdata = s.pin_s2; // R12
            end
         end
         default: begin
            n.state = ST_IDLE;
         end
      endcase

      // No access starts before the pin has changed its role.
      n.req_ready = n.strap_done && n.state == ST_IDLE; // R6

      n.ale     = n.state == ST_ADDR; // R13
      n.fetch_n = !(n.state == ST_STROBE && n.code); // R1 R2
      n.rd_n    = !(n.state == ST_STROBE && !n.code && !n.write);
      n.wr_n    = !(n.state == ST_STROBE && n.write);

      if (n.state == ST_ADDR || n.state == ST_HOLD) begin
         n.port_out = n.addr[`ADDR_PORT_MSB:`ADDR_PORT_LSB]; // R12
         n.port_oe  = 8'hff; // R12
      end else if (n.state == ST_STROBE || n.state == ST_DONE) begin
         n.port_out = n.wdata; // R12
         n.port_oe  = n.write ? 8'hff : 8'h00; // R12
      end else begin
         for (int i = 0; i < 8; i++) begin
            {n.port_out[i], n.port_oe[i]} =
               pin_drive(port_mode_t'(n.mode[2*i +: 2]),
                         n.latch[i], n.boost[i]); // R11
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= CORE_RESET; // R10
      end else begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////

   assign req_ready              = s.req_ready;
   assign resp_valid             = s.resp_valid;
   assign resp_internal          = s.resp_internal;
   assign resp_rdata             = s.rdata;
   assign code_ext_only          = s.ext_only;
   assign port_read              = s.port_read;
   assign program_fetch_strobe_n = s.fetch_n;
   assign read_strobe_n          = s.rd_n;
   assign write_strobe_n         = s.wr_n;
   assign address_latch_enable   = s.ale;
   assign bus_clock_output       = s.clk_out;
   assign bus_addr               = s.addr;
   assign low_byte_port_out      = s.port_out;
   assign low_byte_port_oe       = s.port_oe;

   ////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   logic take;
   assign take = s.state == ST_IDLE && req_valid && s.req_ready;

   AST_FETCH_LOW: assert property ( // R1
      s.state == ST_STROBE && s.code |-> !program_fetch_strobe_n)
      else $error("fetch strobe not low in external code read");

   AST_FETCH_ONLY_EXT: assert property ( // R2
      !program_fetch_strobe_n |-> s.code && s.ext && s.state == ST_STROBE)
      else $error("fetch strobe active outside external code fetch");

   AST_STRAP_HOLD: assert property ( // R3
      s.strap_done && $past(s.strap_done) |-> $stable(s.ext_only))
      else $error("latched code source changed after reset");

   AST_EXT_ONLY: assert property ( // R4
      take && req_code && s.ext_only |=> s.state == ST_ADDR && s.ext
      ##3 !program_fetch_strobe_n)
      else $error("code fetch not external with strap zero");

   AST_INT_BELOW: assert property ( // R5
      take && req_code && !s.ext_only &&
      ({1'b0, req_addr} < 25'(INT_CODE_BYTES))
      |=> resp_valid && resp_internal && s.state == ST_IDLE)
      else $error("internal code fetch went off chip");

   AST_PIN_ROLE: assert property ( // R6
      s.state != ST_IDLE |-> s.strap_done)
      else $error("bus access before pin became wait input");

   AST_WAIT_STRETCH: assert property ( // R7
      s.state == ST_STROBE && s.wsync2 |=> s.state == ST_STROBE)
      else $error("bus cycle ended while wait high");

   AST_WAIT_END: assert property ( // R14
      s.state == ST_STROBE && !s.wsync2 && s.cnt >= STROBE_MIN
      |=> s.state == ST_DONE ##1 resp_valid)
      else $error("bus cycle not ended after wait low");

   AST_CLK_TOGGLE: assert property ( // R8
      !$past(reset) && $past(clk_out_en)
      |-> bus_clock_output != $past(bus_clock_output))
      else $error("bus clock output not following cpu clock");

   AST_CLK_OFF: assert property ( // R9
      !$past(reset) && !$past(clk_out_en) |-> !bus_clock_output)
      else $error("bus clock output active while disabled");

   AST_PORT_RESET: assert property ( // R10
      $past(reset) |-> s.latch == 8'hff && s.mode == 16'h0000 &&
      low_byte_port_oe == 8'h00)
      else $error("low port not reset to ones and quasi mode");

   AST_PORT_PUSH_PULL: assert property ( // R11
      s.state == ST_IDLE && s.mode[3:2] == 2'h1
      |-> low_byte_port_oe[1] && low_byte_port_out[1] == s.latch[1])
      else $error("push-pull pin not driving its latch");

   AST_ADDR_PHASE: assert property ( // R12
      address_latch_enable |-> low_byte_port_oe == 8'hff &&
      low_byte_port_out == s.addr[11:4]
      ##1 low_byte_port_out == s.addr[11:4])
      else $error("low port not carrying address 11 to 4");

   AST_ALE_PULSE: assert property ( // R13
      $rose(address_latch_enable) |-> s.state == ST_ADDR && s.ext
      ##1 !address_latch_enable)
      else $error("address latch pulse wrong");

   COV_EXT_FETCH: cover property (
      take && req_code ##1 s.state == ST_ADDR);
   COV_INT_FETCH: cover property (take ##1 resp_internal);
   COV_STRETCH: cover property (
      s.state == ST_STROBE && s.wsync2 ##1 s.state == ST_STROBE);
   COV_DATA_WRITE: cover property (!write_strobe_n ##[1:20] resp_valid);

endmodule

`default_nettype wire

// ==== verilog/ext_bus_cfg.svh ====
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH

// Bytes of on-chip code memory reachable when the strap reads as one.
`define INT_CODE_BYTES 32'h0000_8000
// Least number of clocks the read or write strobe stays active.
`define STROBE_MIN_CYCLES 4'h2
// Clocks after reset release before the strap pin is trusted.
`define STRAP_SETTLE_CYCLES 3'h3
`define PORT_LATCH_RESET 8'hff
`define PORT_MODE_RESET 16'h0000
`define MODE_FIELD_BITS 2
`define ADDR_PORT_LSB 4
`define ADDR_PORT_MSB 11

`endif

// ==== verilog/ext_bus_pkg.sv ====
package ext_bus_pkg;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_ADDR   = 3'h1,
      ST_HOLD   = 3'h2,
      ST_STROBE = 3'h3,
      ST_DONE   = 3'h4
   } bus_state_t;

   typedef enum logic [1:0] {
      MODE_QUASI      = 2'h0,
      MODE_PUSH_PULL  = 2'h1,
      MODE_OPEN_DRAIN = 2'h2,
      MODE_INPUT_ONLY = 2'h3
   } port_mode_t;

   typedef struct packed {
      bus_state_t  state;
      logic [3:0]  cnt;
      logic [2:0]  settle;
      logic        strap_done;
      logic        ext_only;
      logic        wsync1;
      logic        wsync2;
      logic [7:0]  pin_s1;
      logic [7:0]  pin_s2;
      logic        code;
      logic        ext;
      logic        write;
      logic [23:0] addr;
      logic [7:0]  wdata;
      logic [7:0]  rdata;
      logic [7:0]  latch;
      logic [15:0] mode;
      logic [7:0]  boost;
      logic        fetch_n;
      logic        rd_n;
      logic        wr_n;
      logic        ale;
      logic        clk_out;
      logic [7:0]  port_out;
      logic [7:0]  port_oe;
      logic [7:0]  port_read;
      logic        req_ready;
      logic        resp_valid;
      logic        resp_internal;
   } core_state_t;

   typedef struct packed {
      logic wait_cap;
   } link_state_t;

endpackage

// ==== verilog/pin_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none

interface pin_link_if;
   logic wait_level;
   modport link (output wait_level);
   modport core (input wait_level);
endinterface

`default_nettype wire

// ==== verilog/link_capture.sv ====
`timescale 1ns/100ps
`default_nettype none

// Registers the shared strap and wait pin on the clock of the external
// wait-state logic, so that the core sees a clean level to synchronise.
module link_capture
   import ext_bus_pkg::*;
(
   input  wire logic  link_clk,
   input  wire logic  wait_pin,
   pin_link_if.link   lk
);

   link_state_t st;
   link_state_t next_st;

   always_comb begin
      next_st          = st;
      next_st.wait_cap = wait_pin;
   end

   always_ff @(posedge link_clk) begin
      st <= next_st;
   end

   assign lk.wait_level = st.wait_cap;

endmodule

`default_nettype wire

// ==== dv/ext_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// External memory with wait-state logic clocked by the link clock.
module ext_mem_model (
   input  wire logic       clk,
   input  wire logic       link_clk,
   input  wire logic       ale,
   input  wire logic       fetch_n,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   input  wire logic [7:0] port_out,
   input  wire logic [7:0] port_oe,
   input  wire logic       strap_hold,
   input  wire logic       strap_val,
   input  wire logic [3:0] wait_len,
   output logic [7:0]      port_in,
   output logic            wait_pin,
   output logic [7:0]      addr_seen,
   output logic [7:0]      wr_seen
);
   logic [3:0] wait_cnt = 4'h0;
   logic       drive;

   initial addr_seen = 8'h00;
   initial wr_seen = 8'h00;

   always @(posedge clk) begin
      if (ale) addr_seen <= port_out;
      if (!wr_n) wr_seen <= port_out;
   end

   // Wait is held high until the strobe has been low for wait_len link
   // clocks; a stale count clears once every strobe is back high.
   always @(posedge link_clk) begin
      if (fetch_n && rd_n && wr_n) wait_cnt <= 4'h0;
      else if (wait_cnt < wait_len) wait_cnt <= wait_cnt + 4'h1;
   end

   assign wait_pin = strap_hold ? strap_val : (wait_cnt < wait_len);
   assign drive = !fetch_n || !rd_n;
   // Undriven pins sit at the quasi-bidirectional pull-up level unless a fetch or read strobe makes the memory drive them.
   assign port_in = (port_oe & port_out) |
                    (~port_oe & (drive ? (addr_seen ^ 8'ha5) : 8'hff));
endmodule

`default_nettype wire

// ==== dv/tb_ext_bus_pins.sv ====
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
$display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end

module tb_ext_bus_pins;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic reset = 1'b1;
   logic req_valid = 1'b0;
   logic req_code = 1'b0;
   logic req_write = 1'b0;
   logic [23:0] req_addr = 24'h0;
   logic [7:0] req_wdata = 8'h00;
   logic clk_out_en = 1'b0;
   logic cfg_wr = 1'b0;
   logic [15:0] cfg_mode = 16'h0000;
   logic latch_wr = 1'b0;
   logic [7:0] latch_data = 8'hff;
   logic strap_hold = 1'b1;
   logic strap_val = 1'b1;
   logic [3:0] wait_len = 4'h0;
   logic req_ready, resp_valid, resp_internal, code_ext_only, pin_wait;
   logic program_fetch_strobe_n, read_strobe_n, write_strobe_n;
   logic address_latch_enable, bus_clock_output, got_int;
   logic [7:0] resp_rdata, port_read, port_in, port_out, port_oe;
   logic [7:0] addr_seen, wr_seen, ale_port, c0;
   logic [23:0] bus_addr;
   int bad_count = 0;
   int total_checks = 0;
   int cycles = 0;
   int n_ale, n_fetch, n_rd, n_wr, n_cyc;

   always #4 clk = ~clk;
   always #7.5 link_clk = ~link_clk;

   ext_bus_pins #(.INT_CODE_BYTES(256)) i_ext_bus_pins (
      .clk(clk), .reset(reset), .link_clk(link_clk),
      .code_source_select_n(pin_wait), .req_valid(req_valid),
      .req_ready(req_ready), .req_code(req_code), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .resp_valid(resp_valid),
      .resp_internal(resp_internal), .resp_rdata(resp_rdata),
      .code_ext_only(code_ext_only), .clk_out_en(clk_out_en),
      .cfg_wr(cfg_wr), .cfg_mode(cfg_mode), .latch_wr(latch_wr),
      .latch_data(latch_data), .port_read(port_read),
      .program_fetch_strobe_n(program_fetch_strobe_n),
      .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
      .address_latch_enable(address_latch_enable),
      .bus_clock_output(bus_clock_output), .bus_addr(bus_addr),
      .low_byte_port_in(port_in), .low_byte_port_out(port_out),
      .low_byte_port_oe(port_oe));

   ext_mem_model i_ext_mem_model (
      .clk(clk), .link_clk(link_clk), .ale(address_latch_enable),
      .fetch_n(program_fetch_strobe_n), .rd_n(read_strobe_n),
      .wr_n(write_strobe_n), .port_out(port_out), .port_oe(port_oe),
      .strap_hold(strap_hold), .strap_val(strap_val),
      .wait_len(wait_len), .port_in(port_in), .wait_pin(pin_wait),
      .addr_seen(addr_seen), .wr_seen(wr_seen));

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         results();
      end
   end

   task automatic do_reset(input logic s);
      int k;
      @(posedge clk);
      strap_hold <= 1'b1;
      strap_val <= s;
      reset <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      `CHK(program_fetch_strobe_n, 1'b1)
      `CHK(port_out, 8'hff)
      `CHK(port_oe, 8'h00)
      `CHK(address_latch_enable, 1'b0)
      @(posedge clk);
      reset <= 1'b0;
      for (k = 0; k < 20 && req_ready !== 1'b1; k++) @(posedge clk);
      `CHK(code_ext_only, !s)
      repeat (4) @(posedge clk);
      strap_hold <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      `CHK(port_read, 8'hff)
      $display("reset test done");
   endtask

   // One request; counts strobe and latch cycles until the answer.
   task automatic access(input logic c, w, input logic [23:0] a,
                         input logic [7:0] d);
      int k;
      {n_ale, n_fetch, n_rd, n_wr, n_cyc} = '0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_code <= c;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (req_ready === 1'b1) break;
      end
      req_valid <= 1'b0;
      // The first look is just after the taking edge, where an internal
      // answer already stands for its single cycle.
      for (k = 0; k < 200; k++) begin
         #1;
         n_cyc++;
         if (address_latch_enable === 1'b1) begin
            n_ale++;
            ale_port = port_out & port_oe;
         end
         n_fetch += (program_fetch_strobe_n === 1'b0);
         n_rd += (read_strobe_n === 1'b0);
         n_wr += (write_strobe_n === 1'b0);
         got_int = resp_internal;
         if (resp_valid === 1'b1) break;
         @(posedge clk);
      end
   endtask

   task automatic t_fetch;
      access(1'b1, 1'b0, 24'h000010, 8'h00);
      `CHK(got_int, 1'b1)
      `CHK(n_cyc, 1)
      `CHK(n_ale + n_fetch, 0)
      access(1'b1, 1'b0, 24'h001234, 8'h00);
      `CHK(got_int, 1'b0)
      `CHK(n_ale, 1)
      `CHK(ale_port, 8'h23)
      `CHK(n_fetch, 2)
      `CHK(n_cyc, 6)
      `CHK(bus_addr, 24'h001234)
      `CHK(resp_rdata, 8'h23 ^ 8'ha5)
      $display("fetch test done");
   endtask

   task automatic t_wait;
      wait_len <= 4'h4;
      access(1'b1, 1'b0, 24'h0abcd0, 8'h00);
      `CHK(n_fetch >= 5 && n_fetch <= 14, 1'b1)
      `CHK(resp_rdata, 8'hcd ^ 8'ha5)
      access(1'b1, 1'b0, 24'h000020, 8'h00);
      `CHK(got_int, 1'b1)
      wait_len <= 4'h0;
      repeat (8) @(posedge clk);
      $display("wait test done");
   endtask

   task automatic t_data;
      access(1'b0, 1'b1, 24'h000450, 8'h3c);
      `CHK(n_ale, 1)
      `CHK(wr_seen, 8'h3c)
      `CHK(n_fetch + n_rd, 0)
      access(1'b0, 1'b0, 24'h000780, 8'h00);
      `CHK(n_rd > 0 && n_fetch == 0, 1'b1)
      `CHK(resp_rdata, 8'h78 ^ 8'ha5)
      $display("data test done");
   endtask

   task automatic t_bus_clock_output;
      @(posedge clk);
      clk_out_en <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      c0 = {7'h0, bus_clock_output};
      @(posedge clk);
      #1;
      `CHK(bus_clock_output, ~c0[0])
      @(posedge clk);
      #1;
      `CHK(bus_clock_output, c0[0])
      @(posedge clk);
      clk_out_en <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      `CHK(bus_clock_output, 1'b0)
      @(posedge clk);
      #1;
      `CHK(bus_clock_output, 1'b0)
      $display("clock output test done");
   endtask

   // Pins 0..3 and 4..7 take the four modes in code order.
   task automatic t_port;
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_mode <= 16'he4e4;
      latch_wr <= 1'b1;
      latch_data <= 8'h5a;
      @(posedge clk);
      cfg_wr <= 1'b0;
      latch_wr <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      `CHK(port_oe, 8'h27)
      `CHK(port_out & port_oe, 8'h02)
      repeat (3) @(posedge clk);
      #1;
      `CHK(port_read, 8'hda)
      $display("port test done");
   endtask

   task automatic t_strap0;
      access(1'b1, 1'b0, 24'h000010, 8'h00);
      `CHK(got_int, 1'b0)
      `CHK(n_fetch, 2)
      `CHK(ale_port, 8'h01)
      $display("external only test done");
   endtask

   initial begin
      do_reset(1'b1);
      t_fetch();
      t_wait();
      t_data();
      t_bus_clock_output();
      t_port();
      do_reset(1'b0);
      t_strap0();
      results();
   end
endmodule

`default_nettype wire
